// File: logic/cascadable_reload_timers.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
//Contract
// RULE1: timer0 start loads both reload bytes
// RULE2: reload writes wait for next start; the code also loads them at an auto-reload underflow
// RULE3: timer1 start loads both reload bytes
// RULE4: host avoids count reads during reception
// RULE5: receive-stop halts timer1 after four bits
// RULE6: trimming mode disables receive-stop
// RULE7: mode 00 manual, 01 starts at tx end
// RULE8: modes 10/11 trim on lfo edges
// RULE9: auto-reload restarts count at zero
// RULE10: no auto-reload stops at zero
// RULE11: timer1 underflow sets its flag
// RULE12: clock 00 carrier, 01 slow tick
// RULE13: timer1 cascades timer0 or timer2 underflow
// RULE14: timer1 config bit layout, reserved zero
// RULE15: running timer decrements once per tick
// RULE16: running bits change only with mask
// RULE17: timer0 cascade sources are timer2, timer1
// RULE18: timer0 high byte is upper count
module cascadable_reload_timers (
    input  wire logic                         i_clock,
    input  wire logic                         i_rst,
    input  wire logic [timer_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [timer_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                         i_write,
    input  wire logic                         i_read,
    input  wire timer_pkg::timer_events_t     i_events,
    output logic      [timer_pkg::DATA_W-1:0] o_rdata,
    output logic                              o_irq,
    output logic                              o_timer0_underflow,
    output logic                              o_timer1_underflow,
    output logic      [timer_pkg::TIMERS-1:0] o_timer_running
);
    import timer_pkg::*;

    top_state_t state_reg;
    top_state_t state_next;

    logic [COUNT_W-1:0] t0_count;
    logic [COUNT_W-1:0] t1_count;
    logic               t0_running;
    logic               t1_running;
    logic               t0_underflow;
    logic               t1_underflow;
    logic               t0_tick;
    logic               t1_tick;
    logic               t0_start;
    logic               t1_start;
    logic               t0_stop;
    logic               t1_stop;
    logic               run_write;

    function automatic logic is_trim(input timer_cfg_t cfg);
        is_trim = (cfg.start_mode == START_TRIM) ||
                  (cfg.start_mode == START_TRIM_UF);
    endfunction : is_trim

    // cascade sources differ per timer, so they come in as arguments
    function automatic logic pick_tick(
        input timer_cfg_t cfg,
        input logic       carrier,
        input logic       slow,
        input logic       casc_a,
        input logic       casc_b
    );
        case (cfg.clock_select)
            CLK_CARRIER: pick_tick = carrier;
            CLK_SLOW:    pick_tick = slow;
            CLK_CASC_A:  pick_tick = casc_a;
            CLK_CASC_B:  pick_tick = casc_b;
            default:     pick_tick = 1'b0;
        endcase
    endfunction : pick_tick

    function automatic logic auto_start(
        input timer_cfg_t    cfg,
        input logic          running,
        input timer_events_t ev
    );
        case (cfg.start_mode)
            START_NONE:    auto_start = 1'b0;  // see RULE7
            START_TX_END:  auto_start = ev.tx_end;  // see RULE7
            START_TRIM:    auto_start = ev.lfo_edge && !running;  // see RULE8
            START_TRIM_UF: auto_start = ev.lfo_edge && !running;
            default:       auto_start = 1'b0;
        endcase
    endfunction : auto_start

    function automatic logic auto_stop(
        input timer_cfg_t    cfg,
        input logic          running,
        input timer_events_t ev
    );
        if (is_trim(cfg)) begin
            auto_stop = ev.lfo_edge && running;
        end else begin
            auto_stop = cfg.receive_stop && ev.rx_first_bits;
        end
    endfunction : auto_stop

    function automatic timer_cfg_t cfg_from_bus(input logic [7:0] data);
        timer_cfg_t cfg;
        cfg = timer_cfg_t'(data);
        cfg.reserved6 = 1'b0;  // see RULE14
        cfg.reserved2 = 1'b0;  // see RULE14
        return cfg;
    endfunction : cfg_from_bus

    // readback masks reserved bits again, whatever the state holds
    function automatic logic [7:0] cfg_to_bus(input timer_cfg_t cfg);
        timer_cfg_t clean;
        clean           = cfg;
        clean.reserved6 = 1'b0;  // see RULE14
        clean.reserved2 = 1'b0;  // see RULE14
        return clean;
    endfunction : cfg_to_bus

    // trimming without underflow stops silently at zero
    function automatic logic parks_at_zero(input timer_cfg_t cfg);
        parks_at_zero = (cfg.start_mode == START_TRIM);  // see RULE8
    endfunction : parks_at_zero

    // high byte on top; both bytes are taken at a start or an auto-reload
    function automatic logic [COUNT_W-1:0] reload_word(
        input logic [7:0] high,
        input logic [7:0] low
    );
        reload_word = {high, low};  // see RULE18
    endfunction : reload_word

    assign run_write = i_write && (i_addr == ADDR_RUN_CONTROL);

    // a masked software write counts as a start or stop event
    always_comb begin
        t0_start = auto_start(state_reg.t0_cfg, t0_running, i_events);
        t1_start = auto_start(state_reg.t1_cfg, t1_running, i_events);
        t0_stop  = auto_stop(state_reg.t0_cfg, t0_running, i_events);
        // receive-stop ignored while trimming, see RULE5 see RULE6
        t1_stop  = auto_stop(state_reg.t1_cfg, t1_running, i_events);
        if (run_write && i_wdata[RUN_MASK_LSB]) begin  // see RULE16
            t0_start = i_wdata[RUN_FLAG_LSB];
            t0_stop  = !i_wdata[RUN_FLAG_LSB];
        end
        if (run_write && i_wdata[RUN_MASK_LSB + 1]) begin  // see RULE16
            t1_start = i_wdata[RUN_FLAG_LSB + 1];
            t1_stop  = !i_wdata[RUN_FLAG_LSB + 1];
        end
    end

    // see RULE17
    assign t0_tick = pick_tick(state_reg.t0_cfg,
                               state_reg.carrier_tick,
                               state_reg.slow_tick,
                               i_events.timer2_underflow,
                               t1_underflow);

    // see RULE12 see RULE13
    assign t1_tick = pick_tick(state_reg.t1_cfg,
                               state_reg.carrier_tick,
                               state_reg.slow_tick,
                               t0_underflow,
                               i_events.timer2_underflow);

    // reload registers feed the channel on its start or auto-reload, see RULE2
    timer_channel u_timer0 (
        .i_clock        (i_clock),
        .i_rst          (i_rst),
        .i_tick         (t0_tick),
        .i_start        (t0_start),
        .i_stop         (t0_stop),
        .i_reload       (reload_word(state_reg.t0_reload_high,
                                     state_reg.t0_reload_low)),
        .i_auto_reload  (state_reg.t0_cfg.auto_reload),
        .i_hold_at_zero (parks_at_zero(state_reg.t0_cfg)),
        .o_count        (t0_count),
        .o_running      (t0_running),
        .o_underflow    (t0_underflow)
    );

    timer_channel u_timer1 (
        .i_clock        (i_clock),
        .i_rst          (i_rst),
        .i_tick         (t1_tick),
        .i_start        (t1_start),
        .i_stop         (t1_stop),
        .i_reload       (reload_word(state_reg.t1_reload_high,
                                     state_reg.t1_reload_low)),
        .i_auto_reload  (state_reg.t1_cfg.auto_reload),
        .i_hold_at_zero (parks_at_zero(state_reg.t1_cfg)),
        .o_count        (t1_count),
        .o_running      (t1_running),
        .o_underflow    (t1_underflow)
    );

    always_comb begin
        logic [TIMERS-1:0] irq_set;
        logic [TIMERS-1:0] irq_clear;
        logic [14:0]       acc_sum;
        irq_set   = '0;
        irq_clear = '0;
        acc_sum   = '0;
        state_next = state_reg;

        // carrier tick jitters by one system cycle; average is exact
        acc_sum = {1'b0, state_reg.phase_acc} + {1'b0, CARRIER_STEP};
        state_next.carrier_tick = 1'b0;
        state_next.slow_tick    = 1'b0;
        if (acc_sum >= {1'b0, ACC_MODULUS}) begin
            state_next.phase_acc    = 14'(acc_sum - {1'b0, ACC_MODULUS});
            state_next.carrier_tick = 1'b1;
            if (state_reg.slow_div == SLOW_DIV_LAST) begin
                state_next.slow_div  = '0;
                state_next.slow_tick = 1'b1;
            end else begin
                state_next.slow_div = state_reg.slow_div + 6'h01;
            end
        end else begin
            state_next.phase_acc = 14'(acc_sum);
        end

        if (i_write) begin
            case (i_addr)
                ADDR_T0_CONFIG: begin
                    state_next.t0_cfg = cfg_from_bus(i_wdata);
                end
                ADDR_T0_RELOAD_HIGH: begin
                    state_next.t0_reload_high = i_wdata;
                end
                ADDR_T0_RELOAD_LOW: begin
                    state_next.t0_reload_low = i_wdata;
                end
                ADDR_T1_CONFIG: begin
                    state_next.t1_cfg = cfg_from_bus(i_wdata);
                end
                ADDR_T1_RELOAD_HIGH: begin
                    state_next.t1_reload_high = i_wdata;
                end
                ADDR_T1_RELOAD_LOW: begin
                    state_next.t1_reload_low = i_wdata;
                end
                ADDR_IRQ_MASK: begin
                    state_next.irq_mask = i_wdata[TIMERS-1:0];
                end
                default: begin
                    state_next.irq_mask = state_reg.irq_mask;
                end
            endcase
        end

        state_next.rdata = 8'h00;
        if (i_read) begin
            case (i_addr)
                ADDR_RUN_CONTROL: begin
                    state_next.rdata = {2'b00, t1_running, t0_running,
                                        4'h0};
                end
                ADDR_T0_CONFIG: begin
                    state_next.rdata = cfg_to_bus(state_reg.t0_cfg);
                end
                ADDR_T0_RELOAD_HIGH: begin
                    state_next.rdata = state_reg.t0_reload_high;
                end
                ADDR_T0_RELOAD_LOW: begin
                    state_next.rdata = state_reg.t0_reload_low;
                end
                // live count, no snapshot: see RULE4
                ADDR_T0_COUNT_HIGH: begin
                    state_next.rdata = t0_count[15:8];
                end
                ADDR_T0_COUNT_LOW: begin
                    state_next.rdata = t0_count[7:0];
                end
                ADDR_T1_CONFIG: begin
                    state_next.rdata = cfg_to_bus(state_reg.t1_cfg);
                end
                ADDR_T1_RELOAD_HIGH: begin
                    state_next.rdata = state_reg.t1_reload_high;
                end
                ADDR_T1_RELOAD_LOW: begin
                    state_next.rdata = state_reg.t1_reload_low;
                end
                ADDR_IRQ_STATUS: begin
                    state_next.rdata = {6'h00, state_reg.irq_status};
                    irq_clear = '1;
                end
                ADDR_IRQ_MASK: begin
                    state_next.rdata = {6'h00, state_reg.irq_mask};
                end
                default: begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end

        irq_set[IRQ_T0_BIT] = t0_underflow;
        irq_set[IRQ_T1_BIT] = t1_underflow;  // see RULE11
        // a set in the clearing cycle survives the read
        state_next.irq_status = (state_reg.irq_status & ~irq_clear) |
                                irq_set;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg.phase_acc      <= '0;
            state_reg.slow_div       <= '0;
            state_reg.carrier_tick   <= 1'b0;
            state_reg.slow_tick      <= 1'b0;
            state_reg.t0_cfg         <= timer_cfg_t'(CONFIG_RESET);
            state_reg.t1_cfg         <= timer_cfg_t'(CONFIG_RESET);
            state_reg.t0_reload_high <= RELOAD_RESET;
            state_reg.t0_reload_low  <= RELOAD_RESET;
            state_reg.t1_reload_high <= RELOAD_RESET;
            state_reg.t1_reload_low  <= RELOAD_RESET;
            state_reg.irq_status     <= IRQ_RESET;
            state_reg.irq_mask       <= IRQ_RESET;
            state_reg.rdata          <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rdata            = state_reg.rdata;
    assign o_irq              = |(state_reg.irq_status & state_reg.irq_mask);
    assign o_timer0_underflow = t0_underflow;
    assign o_timer1_underflow = t1_underflow;
    assign o_timer_running    = {t1_running, t0_running};

endmodule : cascadable_reload_timers

// File: common/timer_pkg.sv
package timer_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 16;
    localparam int TIMERS = 2;

    localparam logic [7:0] ADDR_RUN_CONTROL     = 8'h0e;
    localparam logic [7:0] ADDR_T0_CONFIG       = 8'h0f;
    localparam logic [7:0] ADDR_T0_RELOAD_HIGH  = 8'h10;
    localparam logic [7:0] ADDR_T0_RELOAD_LOW   = 8'h11;
    localparam logic [7:0] ADDR_T0_COUNT_HIGH   = 8'h12;
    localparam logic [7:0] ADDR_T0_COUNT_LOW    = 8'h13;
    localparam logic [7:0] ADDR_T1_CONFIG       = 8'h14;
    localparam logic [7:0] ADDR_T1_RELOAD_HIGH  = 8'h15;
    localparam logic [7:0] ADDR_T1_RELOAD_LOW   = 8'h16;
    localparam logic [7:0] ADDR_IRQ_STATUS      = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK        = 8'h21;

    localparam int RUN_FLAG_LSB = 4;
    localparam int RUN_MASK_LSB = 0;
    localparam int IRQ_T0_BIT = 0;
    localparam int IRQ_T1_BIT = 1;

    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET    = 2'h0;

    // carrier tick made by a fractional accumulator: exact on average
    localparam int SYS_CLOCK_HZ  = 100_000_000;
    localparam int CARRIER_HZ    = 13_560_000;
    localparam int SLOW_TICK_HZ  = 211_875;
    localparam int ACC_SCALE     = 10_000;
    localparam logic [13:0] CARRIER_STEP = 14'(CARRIER_HZ / ACC_SCALE);
    localparam logic [13:0] ACC_MODULUS  = 14'(SYS_CLOCK_HZ / ACC_SCALE);
    localparam logic [5:0]  SLOW_DIV_LAST =
        6'(CARRIER_HZ / SLOW_TICK_HZ - 1);

    typedef enum logic [1:0] {
        START_NONE    = 2'b00,
        START_TX_END  = 2'b01,
        START_TRIM    = 2'b10,
        START_TRIM_UF = 2'b11
    } start_mode_t;

    typedef enum logic [1:0] {
        CLK_CARRIER = 2'b00,
        CLK_SLOW    = 2'b01,
        CLK_CASC_A  = 2'b10,
        CLK_CASC_B  = 2'b11
    } clk_sel_t;

    typedef struct packed {
        logic        receive_stop;
        logic        reserved6;
        start_mode_t start_mode;
        logic        auto_reload;
        logic        reserved2;
        clk_sel_t    clock_select;
    } timer_cfg_t;

    typedef struct packed {
        logic tx_end;
        logic rx_first_bits;
        logic lfo_edge;
        logic timer2_underflow;
    } timer_events_t;

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic               running;
        logic               underflow;
    } chan_state_t;

    typedef struct packed {
        logic [13:0]       phase_acc;
        logic [5:0]        slow_div;
        logic              carrier_tick;
        logic              slow_tick;
        timer_cfg_t        t0_cfg;
        timer_cfg_t        t1_cfg;
        logic [7:0]        t0_reload_high;
        logic [7:0]        t0_reload_low;
        logic [7:0]        t1_reload_high;
        logic [7:0]        t1_reload_low;
        logic [TIMERS-1:0] irq_status;
        logic [TIMERS-1:0] irq_mask;
        logic [7:0]        rdata;
    } top_state_t;

endpackage : timer_pkg

// File: logic/timer_channel.sv
`timescale 1ns/10ps
module timer_channel (
    input  wire logic                          i_clock,
    input  wire logic                          i_rst,
    input  wire logic                          i_tick,
    input  wire logic                          i_start,
    input  wire logic                          i_stop,
    input  wire logic [timer_pkg::COUNT_W-1:0] i_reload,
    input  wire logic                          i_auto_reload,
    input  wire logic                          i_hold_at_zero,
    output logic      [timer_pkg::COUNT_W-1:0] o_count,
    output logic                               o_running,
    output logic                               o_underflow
);
    import timer_pkg::*;

    chan_state_t state_reg;
    chan_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.underflow = 1'b0;
        if (i_stop) begin
            state_next.running = 1'b0;
        end else if (i_start) begin
            state_next.count   = i_reload;  // see RULE1 see RULE3 see RULE18
            state_next.running = 1'b1;
        end else if (state_reg.running && i_tick) begin
            if (state_reg.count == '0) begin
                if (i_hold_at_zero) begin
                    // trimming without underflow parks at zero silently
                    state_next.running = 1'b0;  // see RULE8
                end else begin
                    state_next.underflow = 1'b1;
                    if (i_auto_reload) begin
                        state_next.count = i_reload;  // see RULE9
                    end else begin
                        state_next.running = 1'b0;  // see RULE10
                    end
                end
            end else begin
                state_next.count = state_reg.count - 16'h0001;  // see RULE15
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_count     = state_reg.count;
    assign o_running   = state_reg.running;
    // registered pulse also breaks the loop between cascaded timers
    assign o_underflow = state_reg.underflow;

endmodule : timer_channel

// File: testbench/cascadable_reload_timers_asserts.sv
`timescale 1ns/10ps
module cascadable_reload_timers_asserts (
    input wire logic                     i_clock,
    input wire logic                     i_rst,
    input wire logic [7:0]               i_addr,
    input wire logic [7:0]               i_wdata,
    input wire logic                     i_write,
    input wire logic                     i_read,
    input wire timer_pkg::timer_events_t i_events,
    input wire logic [7:0]               o_rdata,
    input wire logic                     o_irq,
    input wire logic                     o_timer0_underflow,
    input wire logic                     o_timer1_underflow,
    input wire logic [1:0]               o_timer_running
);
    import timer_pkg::*;
    // shadow of the timer1 config, rebuilt from bus writes
    logic [7:0] cfg_reg;
    logic       run_wr;
    assign run_wr = i_write && i_addr == ADDR_RUN_CONTROL;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cfg_reg <= 8'h00;
        end else if (i_write && i_addr == ADDR_T1_CONFIG) begin
            cfg_reg <= i_wdata;
        end
    end
    a_cfg_readback: assert property (i_read && i_addr == ADDR_T1_CONFIG
        |=> o_rdata == ($past(cfg_reg) & 8'hbb))
        else $error("timer1 config readback wrong");
    a_mask_start: assert property (run_wr && i_wdata[0] && i_wdata[4]
        && i_events == '0 |=> o_timer_running[0])
        else $error("masked start ignored");
    a_mask_hold: assert property (run_wr && i_wdata[1:0] == 2'h0
        && i_events == '0 |=> $stable(o_timer_running)
        || o_timer0_underflow || o_timer1_underflow)
        else $error("run bit changed without mask");
    a_irq_cause: assert property ($rose(o_irq) |-> $past(o_timer0_underflow)
        || $past(o_timer1_underflow) || $past(i_write))
        else $error("irq rose without underflow");
    a_uf_stops: assert property (o_timer1_underflow && !cfg_reg[3]
        && !i_events.tx_end |-> !o_timer_running[1])
        else $error("timer1 kept running after underflow");
    a_uf_from_run: assert property (o_timer1_underflow
        |-> $past(o_timer_running[1]) ##1 !o_timer1_underflow)
        else $error("timer1 underflow while stopped");
    a_rx_halt: assert property (i_events.rx_first_bits && cfg_reg[7]
        && !cfg_reg[5] && !run_wr |=> !o_timer_running[1])
        else $error("receive stop ignored");
    a_trim_no_rx: assert property (i_events == 4'h4 && cfg_reg[5]
        && o_timer_running[1] && !run_wr
        |=> o_timer_running[1] || o_timer1_underflow)
        else $error("receive stop acted in trim mode");
    a_tx_start: assert property (i_events == 4'h8 && cfg_reg[5:4] == 2'b01
        && !run_wr |=> o_timer_running[1])
        else $error("tx end did not start timer1");
endmodule : cascadable_reload_timers_asserts
bind cascadable_reload_timers cascadable_reload_timers_asserts u_chk (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .i_events(i_events), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_timer0_underflow(o_timer0_underflow),
    .o_timer1_underflow(o_timer1_underflow),
    .o_timer_running(o_timer_running));

// File: testbench/cascadable_reload_timers_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
    n_tests++; \
    if ((got) !== (ex)) begin \
        failures++; \
        $display("BAD %s exp %h saw %h", nm, ex, got); \
    end \
end
module cascadable_reload_timers_tb;
    import timer_pkg::*;
    logic          i_clock;
    logic          i_rst;
    logic [7:0]    i_addr;
    logic [7:0]    i_wdata;
    logic          i_write;
    logic          i_read;
    timer_events_t i_events;
    logic [7:0]    o_rdata;
    logic          o_irq;
    logic          o_timer0_underflow;
    logic          o_timer1_underflow;
    logic [1:0]    o_timer_running;
    int            failures = 0;
    int            n_tests = 0;
    int            cycles = 0;
    int            n_uf0 = 0;
    int            n_uf1 = 0;
    logic [7:0]    rd_val;
    cascadable_reload_timers u_cascadable_reload_timers (
        .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
        .i_events(i_events), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_timer0_underflow(o_timer0_underflow),
        .o_timer1_underflow(o_timer1_underflow),
        .o_timer_running(o_timer_running));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        // ceiling well above the ~2500 cycles the tests take
        if (cycles == 30000) begin
            failures++;
            $display("BAD timeout exp done saw hang");
            give_verdict();
        end
    end
    // pulses stand one cycle; count them away from the launching edge
    always @(negedge i_clock) begin
        n_uf0 += int'(o_timer0_underflow === 1'b1);
        n_uf1 += int'(o_timer1_underflow === 1'b1);
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask : rd
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
        rd(a);
        `CHK(nm, e, rd_val)
    endtask : rdc
    // one-cycle event pulse, then time for cascades to settle
    task automatic ev(input timer_events_t e);
        @(posedge i_clock);
        i_events <= e;
        @(posedge i_clock);
        i_events <= '0;
        repeat (4) @(posedge i_clock);
        #1;
    endtask : ev
    task automatic step(input logic [7:0] c, input timer_events_t e,
                        input logic x);
        wr(ADDR_T1_CONFIG, c);
        ev(e);
        `CHK("ev run", x, o_timer_running[1])
    endtask : step
    initial begin
        i_rst = 1'b1;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_write = 1'b0;
        i_read = 1'b0;
        i_events = '0;
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        rdc("t1cfg", ADDR_T1_CONFIG, 8'h00);
        rdc("t1rh", ADDR_T1_RELOAD_HIGH, 8'h00);
        wr(ADDR_T1_CONFIG, 8'hff);
        rdc("rsvd", ADDR_T1_CONFIG, 8'hbb);
        wr(ADDR_T0_COUNT_LOW, 8'h77);
        rdc("ro", ADDR_T0_COUNT_LOW, 8'h00);
        rdc("unmap", 8'h30, 8'h00);
        $display("registers done");
        wr(ADDR_T0_RELOAD_HIGH, 8'h12);
        wr(ADDR_T0_RELOAD_LOW, 8'h34);
        wr(ADDR_T0_CONFIG, 8'h02);
        wr(ADDR_RUN_CONTROL, 8'h11);
        rdc("cnt hi", ADDR_T0_COUNT_HIGH, 8'h12);
        rdc("cnt lo", ADDR_T0_COUNT_LOW, 8'h34);
        wr(ADDR_T0_RELOAD_LOW, 8'h56);
        rdc("kept", ADDR_T0_COUNT_LOW, 8'h34);
        repeat (3) ev(4'h1);
        rdc("dec", ADDR_T0_COUNT_LOW, 8'h31);
        wr(ADDR_RUN_CONTROL, 8'he0);
        rdc("nomask", ADDR_RUN_CONTROL, 8'h10);
        wr(ADDR_RUN_CONTROL, 8'h11);
        rdc("reload", ADDR_T0_COUNT_LOW, 8'h56);
        wr(ADDR_RUN_CONTROL, 8'h01);
        ev(4'h1);
        rdc("halt", ADDR_T0_COUNT_LOW, 8'h56);
        $display("timer0 done");
        wr(ADDR_T0_RELOAD_HIGH, 8'h00);
        wr(ADDR_T0_RELOAD_LOW, 8'h01);
        wr(ADDR_T0_CONFIG, 8'h0a);
        wr(ADDR_T1_RELOAD_LOW, 8'h01);
        wr(ADDR_T1_CONFIG, 8'h02);
        wr(ADDR_IRQ_MASK, 8'h02);
        wr(ADDR_RUN_CONTROL, 8'h33);
        repeat (3) ev(4'h1);
        `CHK("t1 on", 1'b1, o_timer_running[1])
        ev(4'h1);
        `CHK("t1 off", 2'b01, o_timer_running)
        `CHK("t1 uf", 1, n_uf1)
        `CHK("t0 uf", 2, n_uf0)
        `CHK("irq", 1'b1, o_irq)
        rdc("t0 auto", ADDR_T0_COUNT_LOW, 8'h01);
        rdc("stat", ADDR_IRQ_STATUS, 8'h03);
        `CHK("irq clr", 1'b0, o_irq)
        wr(ADDR_T1_CONFIG, 8'h0a);
        wr(ADDR_RUN_CONTROL, 8'h22);
        repeat (4) ev(4'h1);
        `CHK("t1 auto", 2'b11, o_timer_running)
        rdc("stat2", ADDR_IRQ_STATUS, 8'h03);
        wr(ADDR_RUN_CONTROL, 8'h03);
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_T0_RELOAD_LOW, 8'h05);
        wr(ADDR_T0_CONFIG, 8'h03);
        wr(ADDR_T1_CONFIG, 8'h03);
        wr(ADDR_RUN_CONTROL, 8'h33);
        repeat (2) ev(4'h1);
        rdc("casc", ADDR_T0_COUNT_LOW, 8'h04);
        `CHK("t1 uf3", 3, n_uf1)
        `CHK("masked", 1'b0, o_irq)
        wr(ADDR_IRQ_MASK, 8'h02);
        #1;
        `CHK("unmask", 1'b1, o_irq)
        rdc("stat3", ADDR_IRQ_STATUS, 8'h02);
        $display("cascade done");
        wr(ADDR_RUN_CONTROL, 8'h03);
        wr(ADDR_T0_RELOAD_HIGH, 8'h10);
        wr(ADDR_T0_RELOAD_LOW, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_T0_CONFIG, 8'(k));
            wr(ADDR_RUN_CONTROL, 8'h11);
            repeat (k ? 2000 : 200) @(posedge i_clock);
            rd(ADDR_T0_COUNT_LOW);
            // fractional tick: accept 25 to 30 carrier ticks, or 3 to 6 slow ticks
            `CHK("rate", 1'b1, rd_val >= (k ? 8'hfa : 8'he2) &&
                rd_val <= (k ? 8'hfd : 8'he7))
        end
        wr(ADDR_RUN_CONTROL, 8'h03);
        $display("clocks done");
        step(8'h92, 4'h8, 1'b1);
        step(8'h92, 4'h4, 1'b0);
        step(8'h02, 4'h8, 1'b0);
        step(8'h12, 4'h8, 1'b1);
        step(8'h12, 4'h4, 1'b1);
        step(8'ha2, 4'h2, 1'b0);
        step(8'ha2, 4'h2, 1'b1);
        step(8'ha2, 4'h4, 1'b1);
        step(8'hb2, 4'h2, 1'b0);
        step(8'hb2, 4'h2, 1'b1);
        step(8'hb2, 4'h4, 1'b1);
        $display("events done");
        give_verdict();
    end
endmodule : cascadable_reload_timers_tb
